// ---- pscr_pkg.sv ----
// Package: offsets, field layout, reset values and codes for the protected state control registers
package pscr_pkg;
  localparam logic [6:0] PSCR_ADDR_CLOSED_VIEW = 7'h09;
  localparam logic [6:0] PSCR_ADDR_OPEN_VIEW = 7'h0b;
  localparam logic [6:0] PSCR_ADDR_CTRL = 7'h34;
  localparam logic [6:0] PSCR_ADDR_CTRL_INV = 7'h35;
  localparam logic [6:0] PSCR_CLOSED_RESET = 7'h46;
  localparam logic [6:0] PSCR_OPEN_RESET = 7'h78;
  localparam logic [7:0] PSCR_CTRL_RESET = 8'h00;
  localparam logic [7:0] PSCR_CTRL_INV_RESET = 8'h00;
  localparam int PSCR_MON2_BIT = 7;
  localparam int PSCR_MON1_BIT = 6;
  localparam int PSCR_STEPUP_BIT = 5;
  localparam int PSCR_STEPDN2_BIT = 4;
  localparam int PSCR_UNUSED_BIT = 3;
  localparam logic [2:0] PSCR_REQ_ACTIVE = 3'h1;
  localparam logic [2:0] PSCR_REQ_DISABLED = 3'h3;
  localparam logic [2:0] PSCR_REQ_LOCKED = 3'h7;
  localparam logic [2:0] PSCR_INV_ACTIVE = 3'h6;
  localparam logic [2:0] PSCR_INV_DISABLED = 3'h4;
  localparam logic [2:0] PSCR_INV_LOCKED = 3'h0;
  localparam int PSCR_STEP_CYCLES = 50;
  typedef enum logic [1:0] {
    PSCR_ST_NONE,
    PSCR_ST_ACTIVE,
    PSCR_ST_DISABLED,
    PSCR_ST_LOCKED
  } pscr_state_t;
endpackage : pscr_pkg

// ---- pscr_win_if.sv ----
// Interface: window-size settings carried from the protected config into the read-only view
interface pscr_win_if;
  logic [6:0] closed_window_length;
  logic [6:0] open_span_length;
  modport src (output closed_window_length, output open_span_length);
  modport dst (input closed_window_length, input open_span_length);
endinterface : pscr_win_if

// ---- pscr_window_view.sv ----
// Read-only mirrors of the active watchdog window sizes and their cycle counts
module pscr_window_view
  import pscr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  pscr_win_if.dst win_in,
  output logic [7:0] closed_view_out,
  output logic [7:0] open_view_out,
  output logic [12:0] closed_cycles_out,
  output logic [12:0] open_cycles_out
);
  logic [6:0] closed_q;
  logic [6:0] open_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      closed_q <= PSCR_CLOSED_RESET;
      open_q <= PSCR_OPEN_RESET;
    end else begin
      closed_q <= win_in.closed_window_length;
      open_q <= win_in.open_span_length;
    end
  end

  assign closed_view_out = {1'b0, closed_q};
  assign open_view_out = {1'b0, open_q};
  assign closed_cycles_out = 13'(closed_q * PSCR_STEP_CYCLES);
  assign open_cycles_out = (open_q == 7'h00) ? 13'(PSCR_STEP_CYCLES) : 13'(open_q * PSCR_STEP_CYCLES);

  closed_scale_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    closed_cycles_out == 13'(closed_view_out[6:0] * 50)) else $error("closed window count wrong");
  closed_top_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    closed_view_out[6:0] == 7'h7f |-> closed_cycles_out == 13'd6350) else $error("closed top count wrong");
  open_floor_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    open_view_out[6:1] == 6'h00 |-> open_cycles_out == 13'd50) else $error("open window floor wrong");
  open_top_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    open_view_out[6:0] == 7'h7f |-> open_cycles_out == 13'd6350) else $error("open top count wrong");
  view_follow_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ##1 closed_view_out[6:0] == $past(win_in.closed_window_length)) else $error("view lags config");
  open_follow_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ##1 open_view_out[6:0] == $past(win_in.open_span_length)) else $error("open view lags config");
  top_code_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) closed_cycles_out == 13'd6350);
endmodule : pscr_window_view

// ---- pscr_regs.sv ----
// Protected state control register bank with read-only watchdog window views
module pscr_regs
  import pscr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [6:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [6:0] closed_window_cfg_in,
  input wire logic [6:0] open_window_cfg_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output pscr_pkg::pscr_state_t target_state_request_out,
  output logic monitor_two_enable_request_out,
  output logic monitor_one_enable_request_out,
  output logic step_up_enable_request_out,
  output logic step_down_two_enable_request_out,
  output logic pair_mismatch_out,
  output logic [12:0] closed_cycles_out,
  output logic [12:0] open_cycles_out
);
  import pscr_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_inv_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  pscr_state_t state_q;
  logic [3:0] enables_q;
  logic [7:0] closed_view;
  logic [7:0] open_view;
  logic pair_ok;
  pscr_state_t decoded;

  pscr_win_if win ();
  assign win.closed_window_length = closed_window_cfg_in;
  assign win.open_span_length = open_window_cfg_in;

  pscr_window_view u_view (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .win_in(win),
    .closed_view_out(closed_view),
    .open_view_out(open_view),
    .closed_cycles_out(closed_cycles_out),
    .open_cycles_out(open_cycles_out)
  );

  function automatic pscr_state_t decode_req(input logic [2:0] code);
    pscr_state_t s;
    s = PSCR_ST_NONE;
    if (code == PSCR_REQ_ACTIVE) begin
      s = PSCR_ST_ACTIVE;
    end else if (code == PSCR_REQ_DISABLED) begin
      s = PSCR_ST_DISABLED;
    end else if (code == PSCR_REQ_LOCKED) begin
      s = PSCR_ST_LOCKED;
    end
    return s;
  endfunction

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= PSCR_CTRL_RESET;
    end else if (wr_en_in && addr_in == PSCR_ADDR_CTRL) begin
      ctrl_q <= wdata_in & ~(8'h01 << PSCR_UNUSED_BIT);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_inv_q <= PSCR_CTRL_INV_RESET;
    end else if (wr_en_in && addr_in == PSCR_ADDR_CTRL_INV) begin
      ctrl_inv_q <= wdata_in & ~(8'h01 << PSCR_UNUSED_BIT);
    end
  end

  assign pair_ok = ({ctrl_q[7:4], ctrl_q[2:0]} == ~{ctrl_inv_q[7:4], ctrl_inv_q[2:0]});
  assign decoded = decode_req(ctrl_q[2:0]);
  assign pair_mismatch_out = !pair_ok;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enables_q <= 4'h0;
    end else if (pair_ok) begin
      enables_q <= ctrl_q[7:4];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= PSCR_ST_NONE;
    end else if (pair_ok && decoded != PSCR_ST_NONE) begin
      state_q <= decoded;
    end
  end

  assign target_state_request_out = state_q;
  assign monitor_two_enable_request_out = enables_q[PSCR_MON2_BIT - 4];
  assign monitor_one_enable_request_out = enables_q[PSCR_MON1_BIT - 4];
  assign step_up_enable_request_out = enables_q[PSCR_STEPUP_BIT - 4];
  assign step_down_two_enable_request_out = enables_q[PSCR_STEPDN2_BIT - 4];

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_en_in;
      if (rd_en_in) begin
        if (addr_in == PSCR_ADDR_CLOSED_VIEW) begin
          rdata_q <= closed_view;
        end else if (addr_in == PSCR_ADDR_OPEN_VIEW) begin
          rdata_q <= open_view;
        end else if (addr_in == PSCR_ADDR_CTRL) begin
          rdata_q <= ctrl_q;
        end else if (addr_in == PSCR_ADDR_CTRL_INV) begin
          rdata_q <= ctrl_inv_q;
        end else begin
          rdata_q <= 8'h00;
        end
      end
    end
  end
  assign rdata_out = rdata_q;
  assign rvalid_out = rvalid_q;

  // Checks use the registered pair, so a half-written pair never counts
  // no unpaired change
  single_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !$past(pair_ok) |-> $stable(enables_q)) else $error("enable changed without pair");
  unpaired_state_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !pair_ok |=> $stable(state_q)) else $error("state changed without pair");
  pair_apply_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_ok |=> enables_q == $past(ctrl_q[7:4])) else $error("paired enables not applied");
  active_code_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_ok && ctrl_q[2:0] == 3'h1 |=> state_q == PSCR_ST_ACTIVE) else $error("active not applied");
  disabled_code_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_ok && ctrl_q[2:0] == PSCR_REQ_DISABLED |=> state_q == PSCR_ST_DISABLED)
    else $error("disabled not applied");
  locked_code_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_ok && ctrl_q[2:0] == PSCR_REQ_LOCKED |=> state_q == PSCR_ST_LOCKED)
    else $error("locked code not applied");
  locked_inv_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_ok && ctrl_inv_q[2:0] == 3'h0 |=> state_q == PSCR_ST_LOCKED) else $error("locked not applied");
  active_inv_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_ok && ctrl_inv_q[2:0] == PSCR_INV_ACTIVE |=> state_q == PSCR_ST_ACTIVE)
    else $error("inverse active not applied");
  disabled_inv_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_ok && ctrl_inv_q[2:0] == PSCR_INV_DISABLED |=> state_q == PSCR_ST_DISABLED)
    else $error("inverse disabled not applied");
  reserved_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    decoded == PSCR_ST_NONE |=> state_q == $past(state_q)) else $error("reserved code changed state");
  unused_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ctrl_q[3] == 1'b0 && ctrl_inv_q[3] == 1'b0) else $error("unused bit set");
  inv_disable_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_ok && ctrl_inv_q[4] |=> !step_down_two_enable_request_out) else $error("inverse one did not disable");
  for (genvar b = 0; b < 4; b++) begin : g_inv_bit
    inv_bit_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      pair_ok && ctrl_inv_q[4 + b] |=> !enables_q[b]) else $error("inverse bit did not disable");
  end
  enable_map_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_ok |=> {monitor_two_enable_request_out, monitor_one_enable_request_out, step_up_enable_request_out,
    step_down_two_enable_request_out} == $past(ctrl_q[7:4])) else $error("enable outputs misplaced");
  ctrl_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == PSCR_ADDR_CTRL |=> ctrl_q == ($past(wdata_in) & 8'hf7))
    else $error("control write lost");
  inv_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == PSCR_ADDR_CTRL_INV |=> ctrl_inv_q == ($past(wdata_in) & 8'hf7))
    else $error("inverse write lost");
  mismatch_flag_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pair_mismatch_out == (ctrl_q[7:4] != ~ctrl_inv_q[7:4] || ctrl_q[2:0] != ~ctrl_inv_q[2:0]))
    else $error("mismatch flag wrong");
  view_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && addr_in == 7'h09 |=> rvalid_out && rdata_out[7] == 1'b0) else $error("view read wrong");
  open_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && addr_in == PSCR_ADDR_OPEN_VIEW |=> rvalid_out && rdata_out[7] == 1'b0)
    else $error("open view read wrong");
  ctrl_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && addr_in == PSCR_ADDR_CTRL |=> rdata_out == $past(ctrl_q))
    else $error("control read wrong");
  inv_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && addr_in == PSCR_ADDR_CTRL_INV |=> rdata_out == $past(ctrl_inv_q))
    else $error("inverse read wrong");

  locked_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) state_q == PSCR_ST_LOCKED);
  disabled_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) state_q == PSCR_ST_DISABLED);
  all_en_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) enables_q == 4'hf);
  active_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) state_q == PSCR_ST_ACTIVE && enables_q != 4'h0);
endmodule : pscr_regs

// ---- pscr_host_model.sv ----
// Host microcontroller model driving register reads and writes
module pscr_host_model
  import pscr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [6:0] addr_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 7'h00;
    wdata_out = 8'h00;
  end
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge ref_clk_in);
    wr_en_out <= 1'b0;
    // Released bus shows the inverse so stale data cannot pass
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic write_pair(input logic [7:0] v);
    write_reg(PSCR_ADDR_CTRL, v);
    write_reg(PSCR_ADDR_CTRL_INV, ~v);
  endtask
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge ref_clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    @(posedge ref_clk_in);
    ok = rvalid_in;
    d = rdata_in;
  endtask
endmodule // pscr_host_model

// ---- pscr_regs_tb_top.sv ----
// Testbench for the protected state control register bank
module pscr_regs_tb_top import pscr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr, rd, rv, m2, m1, su, sd2, mis;
  logic [6:0] addr, ccfg, ocfg;
  logic [7:0] wd, rdat;
  logic [12:0] ccyc, ocyc;
  pscr_state_t st;
  int bad_count = 0, compares = 0;
  logic [6:0] codes [4] = '{7'h00, 7'h01, 7'h7f, 7'h7e};
  logic [7:0] vals [3] = '{8'ha1, 8'h53, 8'hff};
  pscr_state_t sts [3] = '{PSCR_ST_ACTIVE, PSCR_ST_DISABLED, PSCR_ST_LOCKED};
  always #20 clk = ~clk;
  pscr_host_model pscr_host_model_i (.ref_clk_in(clk), .rdata_in(rdat), .rvalid_in(rv), .wr_en_out(wr),
    .rd_en_out(rd), .addr_out(addr), .wdata_out(wd));
  pscr_regs pscr_regs_i (.ref_clk_in(clk), .rst_n_in(rst_n), .wr_en_in(wr), .rd_en_in(rd), .addr_in(addr),
    .wdata_in(wd), .closed_window_cfg_in(ccfg), .open_window_cfg_in(ocfg), .rdata_out(rdat), .rvalid_out(rv),
    .target_state_request_out(st), .monitor_two_enable_request_out(m2), .monitor_one_enable_request_out(m1),
    .step_up_enable_request_out(su), .step_down_two_enable_request_out(sd2), .pair_mismatch_out(mis),
    .closed_cycles_out(ccyc), .open_cycles_out(ocyc));
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    pscr_host_model_i.read_reg(a, d, ok);
    chk({12'h0, ok}, 13'h1);
    chk({5'h0, d}, {5'h0, e});
  endtask
  task automatic en_chk(input logic [7:0] v);
    chk({9'h0, m2, m1, su, sd2}, {9'h0, v[7:4]});
  endtask
  task automatic st_chk(input pscr_state_t e);
    chk({11'h0, st}, {11'h0, e});
  endtask
  function automatic logic [12:0] cyc(input logic [6:0] c, input logic open);
    // Open window treats code zero as one step
    return (open && c == 7'h00) ? 13'd50 : 13'(c) * 13'd50;
  endfunction
  task automatic print_verdict;
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    print_verdict;
  end
  initial begin
    ccfg = PSCR_CLOSED_RESET;
    ocfg = PSCR_OPEN_RESET;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(PSCR_ADDR_CLOSED_VIEW, 8'h46);
    rd_chk(PSCR_ADDR_OPEN_VIEW, 8'h78);
    rd_chk(PSCR_ADDR_CTRL, 8'h00);
    st_chk(PSCR_ST_NONE);
    chk({12'h0, mis}, 13'h1);
    foreach (codes[i]) begin
      ccfg <= codes[i];
      ocfg <= ~codes[i];
      repeat (2) @(posedge clk);
      rd_chk(PSCR_ADDR_CLOSED_VIEW, {1'b0, codes[i]});
      rd_chk(PSCR_ADDR_OPEN_VIEW, {1'b0, ~codes[i]});
      chk(ccyc, cyc(codes[i], 1'b0));
      chk(ocyc, cyc(~codes[i], 1'b1));
    end
    pscr_host_model_i.write_reg(PSCR_ADDR_CLOSED_VIEW, 8'hff);
    rd_chk(PSCR_ADDR_CLOSED_VIEW, 8'h7e);
    foreach (vals[i]) begin
      pscr_host_model_i.write_pair(vals[i]);
      repeat (3) @(posedge clk);
      st_chk(sts[i]);
      en_chk(vals[i]);
      chk({12'h0, mis}, 13'h0);
      rd_chk(PSCR_ADDR_CTRL, vals[i] & 8'hf7);
      rd_chk(PSCR_ADDR_CTRL_INV, ~vals[i] & 8'hf7);
    end
    pscr_host_model_i.write_reg(PSCR_ADDR_CTRL, 8'h31);
    repeat (3) @(posedge clk);
    chk({12'h0, mis}, 13'h1);
    st_chk(PSCR_ST_LOCKED);
    en_chk(8'hf0);
    pscr_host_model_i.write_reg(PSCR_ADDR_CTRL_INV, 8'hce);
    repeat (3) @(posedge clk);
    st_chk(PSCR_ST_ACTIVE);
    en_chk(8'h31);
    pscr_host_model_i.write_pair(8'h80);
    repeat (3) @(posedge clk);
    st_chk(PSCR_ST_ACTIVE);
    en_chk(8'h80);
    rd_chk(7'h20, 8'h00);
    print_verdict;
  end
endmodule // pscr_regs_tb_top
